// file: core/hsscc_ctrl.sv
// high-speed system clock control with axi4-lite registers
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module hsscc_ctrl
   import hsscc_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              ce,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // clock sources as one-cycle ticks
   input  wire logic              hs_pad_tick,
   input  wire logic              ih_tick,
   input  wire logic              sub_tick,
   // stop instruction and its release
   input  wire logic              stop_exec,
   input  wire logic              stop_release,
   input  wire logic [7:0]        osc_stable_count_status,
   // pin and oscillator control
   output logic                   port_pin_a_en,
   output logic                   port_pin_b_en,
   output logic                   resonator_pin_a_en,
   output logic                   resonator_pin_b_en,
   output logic                   osc_amp_en,
   output logic                   ext_clk_in_en,
   output logic                   osc_gain_high,
   output logic                   stop_mode,
   // derived clocks as ticks
   output logic                   main_tick,
   output logic                   periph_tick,
   output logic                   cpu_tick
);
   // control registers
   logic                  gain_locked;
   logic                  hs_pin_osc_sel;
   logic                  ext_clock_input_sel;
   logic                  hs_clock_halt;
   logic                  main_clock_hs_sel;
   logic                  periph_clock_hs_sel;
   logic                  cpu_clock_source_sel;
   logic [2:0]            cpu_div;
   logic                  main_clock_src_status;
   logic                  cpu_sub_clock_status;
   hsscc_state_t          state;
   logic [HALT_CNT_W-1:0] halt_cnt;
   // bus side
   logic                  aw_full;
   logic                  w_full;
   logic [ADDR_W-1:0]     aw_addr;
   logic [7:0]            w_byte;
   logic                  w_lane;
   logic                  wr_go;
   logic                  wr_hit;
   logic [4:0]            wr_off;
   logic                  gain_set;
   logic [DATA_W-1:0]     rd_word;
   logic                  res_mode;
   logic                  ext_mode;
   logic                  hs_on;

   // tick streams
   hsscc_tick_if ih_if ();
   hsscc_tick_if hs_if ();
   hsscc_tick_if sub_if ();
   hsscc_tick_if main_if ();
   hsscc_tick_if per_if ();
   hsscc_tick_if div_if ();
   hsscc_tick_if cpu_if ();

   // handshake readies
   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready  = !w_full && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_go         = aw_full && w_full;
   assign wr_off        = {aw_addr[4:2], 2'b00};
   assign wr_hit        = hsscc_reg_hit(aw_addr);

   // write address capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_addr <= 5'h00;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_full <= 1'b0;
         end
      end
   end

   // write data capture, low byte holds every writable field
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full <= 1'b0;
         w_byte <= 8'h00;
         w_lane <= 1'b0;
      end else if (ce) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
         end else if (wr_go) begin
            w_full <= 1'b0;
         end
      end
   end

   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (ce) begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign gain_set = wr_go && w_lane && wr_off == OFF_OSC_PIN &&
                     !gain_locked && w_byte[B_GAIN] != osc_gain_high;

   // oscillator pin control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_gain_high       <= 1'b0;
         gain_locked         <= 1'b0;
         hs_pin_osc_sel      <= 1'b0;
         ext_clock_input_sel <= 1'b0;
      end else if (ce) begin
         if (gain_set) begin
            osc_gain_high <= w_byte[B_GAIN];
            gain_locked   <= 1'b1; // one change per reset
         end
         if (wr_go && w_lane && wr_off == OFF_OSC_PIN && !hs_on) begin
            hs_pin_osc_sel      <= w_byte[B_PINSEL];
            ext_clock_input_sel <= w_byte[B_EXTSEL];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hs_clock_halt <= RST_HALT;
      end else if (ce && wr_go && w_lane && wr_off == OFF_OSC_CTL) begin
         hs_clock_halt <= w_byte[B_HALT];
      end
   end

   // main clock mode register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         main_clock_hs_sel   <= 1'b0;
         periph_clock_hs_sel <= 1'b0;
      end else if (ce && wr_go && w_lane && wr_off == OFF_CLK_MOD) begin
         main_clock_hs_sel <= w_byte[B_MAIN];
         periph_clock_hs_sel <= w_byte[B_PERIPH] | w_byte[B_MAIN];
      end
   end

   // cpu clock control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_clock_source_sel <= 1'b0;
         cpu_div              <= RST_DIV;
      end else if (ce && wr_go && w_lane && wr_off == OFF_CPU_CLK) begin
         cpu_clock_source_sel <= w_byte[B_CSRC];
         if (w_byte[B_DIV+2:B_DIV] <= DIV_MAX) begin
            cpu_div <= w_byte[B_DIV+2:B_DIV];
         end
      end
   end

   // cpu run state: gain pause and stop mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state    <= st_run;
         halt_cnt <= '0;
      end else if (ce) begin
         case (state)
            st_run: begin
               if (gain_set && w_byte[B_GAIN]) begin
                  state    <= st_gain_hold;
                  halt_cnt <= HALT_CNT_W'(GAIN_HALT_CYC - 1);
               end else if (stop_exec) begin
                  state <= st_stop;
               end
            end
            st_gain_hold: begin
               if (halt_cnt == '0) begin
                  state <= st_run;
               end else begin
                  halt_cnt <= halt_cnt - 1'b1;
               end
            end
            st_stop: begin
               if (stop_release) begin
                  state <= st_run;
               end
            end
            default: begin
               state <= st_run;
            end
         endcase
      end
   end

   assign res_mode = hs_pin_osc_sel && !ext_clock_input_sel;
   assign ext_mode = hs_pin_osc_sel && ext_clock_input_sel;
   assign hs_on    = !hs_clock_halt && state != st_stop &&
                     (res_mode || ext_mode);

   // registered pin and oscillator controls
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_pin_a_en      <= 1'b1;
         port_pin_b_en      <= 1'b1;
         resonator_pin_a_en <= 1'b0;
         resonator_pin_b_en <= 1'b0;
         osc_amp_en         <= 1'b0;
         ext_clk_in_en      <= 1'b0;
         stop_mode          <= 1'b0;
      end else if (ce) begin
         resonator_pin_a_en <= res_mode;
         resonator_pin_b_en <= res_mode;
         port_pin_a_en      <= !res_mode;
         port_pin_b_en      <= !hs_pin_osc_sel;
         osc_amp_en         <= hs_on && res_mode;
         ext_clk_in_en      <= hs_on && ext_mode;
         stop_mode          <= state == st_stop;
      end
   end

   // source streams; internal osc also stops in stop mode
   assign ih_if.tick   = ih_tick && state != st_stop;
   assign ih_if.alive  = state != st_stop;
   assign hs_if.tick   = hs_pad_tick && hs_on;
   assign hs_if.alive  = hs_on;
   assign sub_if.tick  = sub_tick;
   assign sub_if.alive = 1'b1;

   hsscc_tick_mux u_main_mux (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .sel_req (main_clock_hs_sel),
      .sel_now (main_clock_src_status),
      .src_a   (ih_if.rcv),
      .src_b   (hs_if.rcv),
      .out     (main_if.drv)
   );

   hsscc_tick_mux u_per_mux (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .sel_req (periph_clock_hs_sel),
      .sel_now (),
      .src_a   (ih_if.rcv),
      .src_b   (hs_if.rcv),
      .out     (per_if.drv)
   );

   hsscc_cpu_div u_div (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .code    (cpu_div),
      .din     (main_if.rcv),
      .dout    (div_if.drv)
   );

   hsscc_tick_mux u_cpu_mux (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .sel_req (cpu_clock_source_sel),
      .sel_now (cpu_sub_clock_status),
      .src_a   (div_if.rcv),
      .src_b   (sub_if.rcv),
      .out     (cpu_if.drv)
   );

   assign main_tick   = main_if.tick;
   assign periph_tick = per_if.tick;
   assign cpu_tick    = cpu_if.tick && state == st_run;

   // read word assembly
   always_comb begin
      rd_word = '0;
      case ({s_axi_araddr[4:2], 2'b00})
         OFF_OSC_PIN: begin
            rd_word[B_GAIN]   = osc_gain_high;
            rd_word[B_PINSEL] = hs_pin_osc_sel;
            rd_word[B_EXTSEL] = ext_clock_input_sel;
         end
         OFF_OSC_CTL: begin
            rd_word[B_HALT] = hs_clock_halt;
         end
         OFF_CLK_MOD: begin
            rd_word[B_PERIPH] = periph_clock_hs_sel;
            rd_word[B_MSTAT]  = main_clock_src_status;
            rd_word[B_MAIN]   = main_clock_hs_sel;
         end
         OFF_CPU_CLK: begin
            rd_word[B_DIV+2:B_DIV] = cpu_div;
            rd_word[B_CSRC]        = cpu_clock_source_sel;
            rd_word[B_CSTAT]       = cpu_sub_clock_status;
         end
         OFF_OSC_STS: begin
            rd_word[7:0]    = osc_stable_count_status;
            rd_word[8]      = stop_mode;
         end
         default: begin
            rd_word = '0;
         end
      endcase
   end

   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= hsscc_reg_hit(s_axi_araddr) ?
                            RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// file: shared/hsscc_pkg.sv
// constants, types and decode helpers of the high-speed clock control
package hsscc_pkg;
   // register bus geometry
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   // register byte offsets
   localparam logic [4:0] OFF_OSC_PIN = 5'h00; // osc_pin_control_reg
   localparam logic [4:0] OFF_OSC_CTL = 5'h04; // main_osc_control_reg
   localparam logic [4:0] OFF_CLK_MOD = 5'h08; // main_clock_mode_reg
   localparam logic [4:0] OFF_CPU_CLK = 5'h0c; // cpu_clock_control_reg
   localparam logic [4:0] OFF_OSC_STS = 5'h10; // osc_stable_count_status
   // field positions
   localparam int B_GAIN   = 0; // osc_gain_high
   localparam int B_PINSEL = 6; // hs_pin_osc_sel
   localparam int B_EXTSEL = 7; // ext_clock_input_sel
   localparam int B_HALT   = 7; // hs_clock_halt
   localparam int B_PERIPH = 0; // periph_clock_hs_sel
   localparam int B_MSTAT  = 1; // main_clock_src_status
   localparam int B_MAIN   = 2; // main_clock_hs_sel
   localparam int B_DIV    = 0; // cpu divider, three bits
   localparam int B_CSRC   = 4; // cpu_clock_source_sel
   localparam int B_CSTAT  = 5; // cpu_sub_clock_status
   localparam int B_STOP   = 7; // unused; the stop mode flag sits in bit 8 of the status word
   // reset values and the largest accepted divider code
   localparam logic       RST_HALT = 1'b1;
   localparam logic [2:0] RST_DIV  = 3'h1;
   localparam logic [2:0] DIV_MAX  = 3'h4;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // cpu clock pause after the gain goes high
   localparam int CLK_PERIOD_NS = 10;
   localparam int GAIN_HALT_NS  = 5000;
   localparam int GAIN_HALT_CYC =
      (GAIN_HALT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HALT_CNT_W = 10;
   // cpu run state
   typedef enum logic [1:0] {
      st_run       = 2'b00,
      st_gain_hold = 2'b01,
      st_stop      = 2'b10
   } hsscc_state_t;
   // true when a byte address hits a mapped register
   function automatic logic hsscc_reg_hit(input logic [4:0] a);
      logic [4:0] w;
      w = {a[4:2], 2'b00};
      return (w == OFF_OSC_PIN) || (w == OFF_OSC_CTL) ||
             (w == OFF_CLK_MOD) || (w == OFF_CPU_CLK) ||
             (w == OFF_OSC_STS);
   endfunction
   // terminal count of the cpu divider for a ratio code
   function automatic logic [3:0] hsscc_div_limit(input logic [2:0] c);
      case (c)
         3'h0: return 4'h0;
         3'h1: return 4'h1;
         3'h2: return 4'h3;
         3'h3: return 4'h7;
         default: return 4'hf;
      endcase
   endfunction
endpackage

// file: shared/hsscc_tick_if.sv
// clock tick stream between the selector and divider stages
`timescale 1ns/1ns
interface hsscc_tick_if;
   logic tick;  // one-cycle pulse per source period
   logic alive; // source is running
   modport drv (output tick, output alive);
   modport rcv (input tick, input alive);
endinterface

// file: core/hsscc_tick_mux.sv
// glitch-free selector between two tick streams
`timescale 1ns/1ns
module hsscc_tick_mux
   import hsscc_pkg::*;
(
   input  wire logic   aclk,
   input  wire logic   aresetn,
   input  wire logic   ce,
   input  wire logic   sel_req,
   output logic        sel_now,
   hsscc_tick_if.rcv   src_a,
   hsscc_tick_if.rcv   src_b,
   hsscc_tick_if.drv   out
);
   logic cur_tick;
   logic cur_alive;

   // current source as seen now
   always_comb begin
      cur_tick  = sel_now ? src_b.tick : src_a.tick;
      cur_alive = sel_now ? src_b.alive : src_a.alive;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_now <= 1'b0;
      end else if (ce && sel_req != sel_now) begin
         if (cur_tick || !cur_alive) begin
            sel_now <= sel_req; // at a period boundary, or at once if the current source is dead
         end
      end
   end

   // selected stream
   assign out.tick  = ce & cur_tick;
   assign out.alive = cur_alive;
endmodule

// file: core/hsscc_cpu_div.sv
// programmable divider of the main clock tick stream
`timescale 1ns/1ns
module hsscc_cpu_div
   import hsscc_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       ce,
   input  wire logic [2:0] code,
   hsscc_tick_if.rcv       din,
   hsscc_tick_if.drv       dout
);
   logic [3:0] cnt;
   logic [3:0] lim;
   logic       wrap;

   assign wrap = cnt >= lim;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 4'h0;
         lim <= hsscc_div_limit(RST_DIV);
      end else if (ce && din.tick) begin
         if (wrap) begin
            cnt <= 4'h0;
            lim <= hsscc_div_limit(code);
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end

   // one output tick per divided period
   assign dout.tick  = ce & din.tick & wrap;
   assign dout.alive = din.alive;
endmodule

// file: tb/hsscc_ctrl_chk.sv
// assertions on the ports of the high-speed clock control
`timescale 1ns/1ns
module hsscc_ctrl_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic stop_exec,
   input wire logic sub_tick,
   input wire logic port_pin_a_en,
   input wire logic port_pin_b_en,
   input wire logic resonator_pin_a_en,
   input wire logic resonator_pin_b_en,
   input wire logic osc_amp_en,
   input wire logic ext_clk_in_en,
   input wire logic osc_gain_high,
   input wire logic stop_mode,
   input wire logic main_tick,
   input wire logic cpu_tick
);
   logic       g_q;
   logic       g_up;
   logic [1:0] n_chg;
   logic [8:0] hold;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   assign g_up = osc_gain_high && !g_q;
   // count gain changes and time the cpu pause after a rise
   always_ff @(posedge aclk) begin
      g_q <= osc_gain_high;
      if (!aresetn) begin
         n_chg <= 2'h0;
         hold  <= 9'h0;
      end else begin
         if (osc_gain_high != g_q && n_chg != 2'h3) n_chg <= n_chg + 2'h1;
         if (g_up) hold <= 9'h1f3;
         else if (hold != 9'h0) hold <= hold - 9'h1;
      end
   end
   property p_rst_pins;
      $rose(aresetn) |-> port_pin_a_en && port_pin_b_en && !osc_amp_en;
   endproperty
   a_rst_pins: assert property (p_rst_pins)
      else $error("pins not in port mode after reset");
   property p_pin_a; port_pin_a_en != resonator_pin_a_en; endproperty
   a_pin_a: assert property (p_pin_a)
      else $error("first pin mode clash");
   property p_osc_pins;
      osc_amp_en |-> resonator_pin_b_en && !port_pin_b_en && !ext_clk_in_en;
   endproperty
   a_osc_pins: assert property (p_osc_pins)
      else $error("oscillator runs outside resonator mode");
   property p_ext_pins; ext_clk_in_en |-> port_pin_a_en && !port_pin_b_en;
   endproperty
   a_ext_pins: assert property (p_ext_pins)
      else $error("external input with wrong pin modes");
   property p_gain_once; n_chg <= 2'h1; endproperty
   a_gain_once: assert property (p_gain_once)
      else $error("gain changed twice");
   property p_pause; g_up || hold != 9'h0 |-> !cpu_tick; endproperty
   a_pause: assert property (p_pause)
      else $error("cpu tick during gain pause");
   property p_stop_in;
      stop_exec && !stop_mode && hold == 9'h0 && !g_up |-> ##[1:3] stop_mode;
   endproperty
   a_stop_in: assert property (p_stop_in)
      else $error("stop not entered");
   property p_stop_off;
      stop_mode && $past(stop_mode) |-> !osc_amp_en && !ext_clk_in_en;
   endproperty
   a_stop_off: assert property (p_stop_off)
      else $error("source alive in stop");
   property p_cpu_src; cpu_tick |-> main_tick || sub_tick; endproperty
   a_cpu_src: assert property (p_cpu_src)
      else $error("cpu tick without source tick");
   c_gain: cover property (g_up);
   c_ext: cover property (ext_clk_in_en);
   c_stop: cover property ($rose(stop_mode));
endmodule
bind hsscc_ctrl hsscc_ctrl_chk i_hsscc_ctrl_chk (.*);

// file: tb/hsscc_pin_src.sv
// behavioural resonator or external clock source on the pins
`timescale 1ns/1ns
module hsscc_pin_src #(parameter int PERIOD = 3) (
   input  wire logic aclk,
   input  wire logic osc_amp_en,
   input  wire logic ext_clk_in_en,
   output logic      hs_pad_tick
);
   int cnt = 0;
   initial hs_pad_tick = 1'h0;
   // pulses only while the pin source is enabled
   always @(posedge aclk) begin
      if (!(osc_amp_en || ext_clk_in_en)) begin
         cnt <= 0;
         hs_pad_tick <= 1'h0;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         hs_pad_tick <= (cnt == PERIOD - 1);
      end
   end
endmodule

// file: tb/testbench.sv
// self-checking bench of the high-speed clock control
`timescale 1ns/1ns
module testbench;
   import hsscc_pkg::*;
   logic        aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
   logic [4:0]  s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        hs_pad_tick, ih_tick = 1'h0, sub_tick = 1'h0;
   logic        stop_exec = 1'h0, stop_release = 1'h0;
   logic [7:0]  osc_stable_count_status = 8'h0;
   logic        port_pin_a_en, port_pin_b_en, resonator_pin_a_en;
   logic        resonator_pin_b_en, osc_amp_en, ext_clk_in_en;
   logic        osc_gain_high, stop_mode, main_tick, periph_tick, cpu_tick;
   int          errors = 0, checked = 0, seed = 97, tc = 0, m, p, c, h;
   hsscc_ctrl i_hsscc_ctrl (.*);
   hsscc_pin_src i_hsscc_pin_src (.*);
   always #5 aclk = ~aclk;
   // internal and subsystem oscillator ticks
   always @(posedge aclk) begin
      tc <= tc + 1;
      ih_tick <= (tc % 2 == 0);
      sub_tick <= (tc % 7 == 0);
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      if (errors == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // write one word, both address and data offered together
   task automatic wchk(input logic [4:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      int   n;
      n = 0;
      tb = 1'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!tb && n < 200) begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         n++;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
      end
      s_axi_bready <= 1'h0;
      if (!tb) errors++;
      chk(r, RESP_OKAY);
      @(posedge aclk);
   endtask
   // read one word
   task automatic rd(input logic [4:0] a);
      logic ta, tr;
      int   n;
      n = 0;
      tr = 1'h0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (!tr && n < 200) begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         n++;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'h0;
      end
      s_axi_rready <= 1'h0;
      if (!tr) errors++;
      @(posedge aclk);
   endtask
   // read until a field settles, then compare it
   task automatic rchk(input logic [4:0] a, input logic [31:0] mk, e);
      int n;
      n = 0;
      do begin
         rd(a);
         n++;
      end while ((d & mk) !== e && n < 30);
      chk(d & mk, e);
      chk(r, RESP_OKAY);
   endtask
   task automatic pins(input logic [5:0] e);
      repeat (2) @(negedge aclk);
      chk({port_pin_a_en, port_pin_b_en, resonator_pin_a_en,
           resonator_pin_b_en, osc_amp_en, ext_clk_in_en}, e);
      @(posedge aclk);
   endtask
   // count tick pulses over a window
   task automatic cnt(input int len);
      m = 0;
      p = 0;
      c = 0;
      h = 0;
      repeat (len) begin
         @(negedge aclk);
         m += main_tick;
         p += periph_tick;
         c += cpu_tick;
         h += hs_pad_tick;
      end
      @(posedge aclk);
   endtask
   // watchdog, well beyond the few thousand cycles the run needs
   initial begin
      #200000;
      errors++;
      close_out;
   end
   // main sequence
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      osc_stable_count_status <= 8'($random(seed));
      pins(6'h30);
      rchk(OFF_OSC_CTL, 32'h80, 32'h80);
      rchk(OFF_CPU_CLK, 32'h7, 32'(RST_DIV));
      rd(5'h14);
      chk(r, RESP_SLVERR);
      wchk(OFF_OSC_PIN, 32'h1);
      cnt(450);
      chk(c, 0);
      cnt(96);
      chk(c != 0, 1);
      rchk(OFF_OSC_PIN, 32'h1, 32'h1);
      chk(osc_gain_high, 1);
      wchk(OFF_OSC_PIN, 32'h0);
      rchk(OFF_OSC_PIN, 32'h1, 32'h1);
      wchk(OFF_OSC_PIN, 32'h41);
      pins(6'h0c);
      wchk(OFF_OSC_CTL, 32'h0);
      pins(6'h0e);
      rchk(OFF_OSC_STS, 32'hff, 32'(osc_stable_count_status));
      wchk(OFF_CLK_MOD, 32'h5);
      rchk(OFF_CLK_MOD, 32'h2, 32'h2);
      cnt(96);
      chk(m, h);
      chk(p, h);
      wchk(OFF_CLK_MOD, 32'h4);
      rchk(OFF_CLK_MOD, 32'h1, 32'h1);
      for (int k = 0; k < 5; k++) begin
         wchk(OFF_CPU_CLK, k);
         repeat (30 + {$random(seed)} % 20) @(posedge aclk);
         cnt(96);
         chk(c + 1 >= (m >> k) && c <= (m >> k) + 1, 1);
      end
      // subsystem clock as cpu source
      wchk(OFF_CPU_CLK, 32'h14);
      rchk(OFF_CPU_CLK, 32'h20, 32'h20);
      cnt(98);
      chk(c, 14);
      wchk(OFF_CPU_CLK, 32'h5 + {$random(seed)} % 3);
      rchk(OFF_CPU_CLK, 32'h7, 32'h4);
      wchk(OFF_CLK_MOD, 32'h0);
      rchk(OFF_CLK_MOD, 32'h2, 32'h0);
      wchk(OFF_OSC_CTL, 32'h80);
      pins(6'h0c);
      wchk(OFF_OSC_PIN, 32'hc1);
      pins(6'h20);
      wchk(OFF_OSC_CTL, 32'h0);
      pins(6'h21);
      stop_exec <= 1'h1;
      @(posedge aclk);
      stop_exec <= 1'h0;
      pins(6'h20);
      rchk(OFF_OSC_STS, 32'h100, 32'h100);
      stop_release <= 1'h1;
      @(posedge aclk);
      stop_release <= 1'h0;
      rchk(OFF_OSC_STS, 32'h100, 32'h0);
      // second reset frees the gain bit again
      aresetn <= 1'h0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      pins(6'h30);
      rchk(OFF_OSC_PIN, 32'h1, 32'h0);
      wchk(OFF_OSC_PIN, 32'h1);
      rchk(OFF_OSC_PIN, 32'h1, 32'h1);
      chk(osc_gain_high, 1);
      close_out;
   end
endmodule
